// File: logic/dow_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - sixteen inputs, or eight outputs plus eight inputs
// - eight bit rates chosen by stored code
// - configuration kept in nonvolatile store
// - factory record: Modbus, address 01, type 40, 9600
// - recovery strap forces address 00, 9600, no checksum
// - rate, checksum, protocol changes only in recovery
// - reset drives outputs to 00, boot end then loads power-on value
// - host timeout drives safe value, status 04
// - timeout flag set: output writes ignored, reply '!'
// - timeout flag stored, cleared only by command
// - power-on value only when timeout flag clear
// - flag clear: output write applies, reply '>'
// - module watchdog restarts a halted device
// - reset flag set on reset, cleared by read
// - low pulses latched between two latched reads
// - saved configuration applies after next power-on
module dow_ctrl
   import dow_pkg::*;
#(
   parameter bit          OUT_EN      = 1'b1,
   parameter int unsigned HWDT_UNIT   = HWDT_UNIT_CYC,
   parameter int unsigned MWDT_LEN    = MWDT_CYC,
   parameter logic [7:0]  PON_DEFAULT = 8'h00,
   parameter logic [7:0]  SAFE_DEFAULT = 8'h00
) (
   input  wire logic            mclk,
   input  wire logic            srst,
   input  wire logic            ce,
   input  wire logic [7:0]      s_axi_awaddr,
   input  wire logic            s_axi_awvalid,
   output logic                 s_axi_awready,
   input  wire logic [31:0]     s_axi_wdata,
   input  wire logic [3:0]      s_axi_wstrb,
   input  wire logic            s_axi_wvalid,
   output logic                 s_axi_wready,
   output logic [1:0]           s_axi_bresp,
   output logic                 s_axi_bvalid,
   input  wire logic            s_axi_bready,
   input  wire logic [7:0]      s_axi_araddr,
   input  wire logic            s_axi_arvalid,
   output logic                 s_axi_arready,
   output logic [31:0]          s_axi_rdata,
   output logic [1:0]           s_axi_rresp,
   output logic                 s_axi_rvalid,
   input  wire logic            s_axi_rready,
   input  wire logic [15:0]     din_pin,
   input  wire logic            recover_n_pin,
   output logic [7:0]           dout,
   input  wire logic            nv_valid,
   input  wire logic [NV_W-1:0] nv_rec,
   input  wire logic            nv_tmo,
   output logic                 nv_rec_wr,
   output logic [NV_W-1:0]      nv_rec_wdata,
   output logic                 nv_tmo_wr,
   output logic                 nv_tmo_wdata,
   output logic [7:0]           dev_addr,
   output logic [15:0]          baud_div,
   output logic                 chk_en,
   output logic                 proto_modbus,
   output logic                 recovery,
   output logic                 mwdt_rst,
   output logic                 irq
);

   localparam logic [15:0] IN_MASK = OUT_EN ? 16'h00ff : 16'hffff;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a[7:2] == off[7:2]);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   // bus slave state
   logic              aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
   logic [7:0]        awaddr_q;
   logic [31:0]       wdata_q, rdata_q;
   logic [3:0]        wstrb_q;
   logic [1:0]        bresp_q, rresp_q;

   // block state
   dow_state_t        st_q;
   logic [2:0]        boot_q;
   logic [15:0]       s1_q, s2_q, s3_q, din_q, latch_q;
   logic              r1_q, r2_q, r3_q, strap_q;
   logic [7:0]        dout_q, pon_q, safe_q, reply_q;
   logic [15:0]       rdat_q, hwdt_int_q, hw_units_q;
   logic [31:0]       hw_tick_q, mw_cnt_q, stage_q;
   logic [NV_W-1:0]   act_q, nvrec_q;
   logic              tmo_q, rst_flag_q, recov_q, mwdt_q, nvw_q, nvt_q;
   logic [IRQ_W-1:0]  irq_stat_q, irq_mask_q;
   logic [7:0]        dev_addr_q;
   logic [15:0]       baud_div_q;
   logic              chk_q, proto_q;

   // bus decode
   wire         wr_go  = aw_hold_q && w_hold_q && !bvalid_q;
   wire         rd_go  = s_axi_arvalid && !rvalid_q;
   wire [31:0]  wword  = merge(32'h0, wdata_q, wstrb_q);
   wire         w_cmd  = wr_go && hit(awaddr_q, A_CMD);
   wire         w_cfg  = wr_go && hit(awaddr_q, A_CFG);
   wire         w_val  = wr_go && hit(awaddr_q, A_VAL);
   wire         w_hwdt = wr_go && hit(awaddr_q, A_HWDT);
   wire         w_mask = wr_go && hit(awaddr_q, A_MASK);
   wire         w_kick = wr_go && hit(awaddr_q, A_KICK);
   wire         w_map  = w_cmd || w_cfg || w_val || w_hwdt || w_mask || w_kick;
   wire [7:0]   ra     = s_axi_araddr;
   wire         r_irq  = rd_go && hit(ra, A_IRQ);
   wire         running = (st_q == ST_RUN);

   // command decode
   wire [3:0]   op      = wword[3:0];
   wire [7:0]   arg     = wword[CMD_ARG +: 8];
   wire [7:0]   sel     = wword[CMD_SEL +: 8];
   wire         cmd_go  = w_cmd && running && (wword[CMD_ADR +: 8] == dev_addr_q);
   wire [15:0]  io_word = {OUT_EN ? dout_q : din_q[15:8], din_q[7:0]};
   wire [15:0]  lt_word = {OUT_EN ? 8'h00 : latch_q[15:8], latch_q[7:0]};
   wire         grp_all = (sel == GRP_A) || (sel == GRP_B);
   wire         grp_one = ((sel[7:4] == SGL_A) || (sel[7:4] == SGL_B)) && !sel[3] && (arg[7:1] == 7'h0);
   wire         new_rate = (stage_q[23:16] != act_q[23:16]);
   wire         new_chk  = (stage_q[24 + FMT_CHK] != act_q[24 + FMT_CHK]);

   logic [7:0]  rep_ch;
   logic [15:0] rep_dat;
   logic        set_out, clr_tmo, clr_rst, rd_latch, rec_go;
   logic [7:0]  out_val;
   logic [NV_W-1:0] rec_val;

   always_comb begin
      rep_ch   = CH_BAD;
      rep_dat  = 16'h0;
      set_out  = 1'b0;
      out_val  = dout_q;
      clr_tmo  = 1'b0;
      clr_rst  = 1'b0;
      rd_latch = 1'b0;
      rec_go   = 1'b0;
      rec_val  = nvrec_q;
      case (op)
         OP_STATUS: begin
            rep_ch  = CH_ACK;
            rep_dat = {8'h00, tmo_q ? STS_TMO : STS_NORM};
         end
         OP_CLR_TMO: begin
            rep_ch  = CH_ACK;
            clr_tmo = 1'b1;
         end
         OP_RST_FLG: begin
            rep_ch  = CH_ACK;
            rep_dat = {15'h0, rst_flag_q};
            clr_rst = 1'b1;
         end
         OP_IO: begin
            rep_ch  = CH_ACK;
            rep_dat = io_word;
         end
         OP_LATCH: begin
            rep_ch   = CH_ACK;
            rep_dat  = lt_word;
            rd_latch = 1'b1;
         end
         OP_OUT_ALL: begin
            if (OUT_EN && tmo_q) begin
               rep_ch = CH_IGN;
            end else if (OUT_EN) begin
               rep_ch  = CH_DONE;
               set_out = 1'b1;
               out_val = arg;
            end
         end
         OP_OUT_GRP: begin
            if (OUT_EN && tmo_q) begin
               rep_ch = CH_IGN;
            end else if (OUT_EN && grp_all) begin
               rep_ch  = CH_DONE;
               set_out = 1'b1;
               out_val = arg;
            end else if (OUT_EN && grp_one) begin
               rep_ch  = CH_DONE;
               set_out = 1'b1;
               out_val[sel[2:0]] = arg[0];
            end
         end
         OP_SET_CFG: begin
            // a changed rate or checksum needs the strap
            if (stage_q[15:8] == FAC_TYPE && (recov_q || !(new_rate || new_chk))) begin
               rep_ch  = CH_ACK;
               rec_go  = 1'b1;
               rec_val = {nvrec_q[NV_W-1], stage_q[31:16], FAC_TYPE, stage_q[7:0]};
            end
         end
         OP_PROTO: begin
            if (recov_q) begin
               rep_ch  = CH_ACK;
               rec_go  = 1'b1;
               rec_val = {arg[0], nvrec_q[31:0]};
            end
         end
         default: ;
      endcase
   end

   // host watchdog; interval in 0.1 s units, zero disables
   wire hw_on   = running && !tmo_q && (hwdt_int_q != 16'h0);
   wire hw_tick = (hw_tick_q == 32'(HWDT_UNIT - 1));
   wire hto_ev  = hw_on && hw_tick && (hw_units_q == hwdt_int_q - 16'h1);
   wire mw_exp  = running && (mw_cnt_q == 32'(MWDT_LEN - 1));
   wire boot_end = (st_q == ST_BOOT) && (boot_q == 3'(BOOT_CYC - 1));
   wire [NV_W-1:0] boot_rec = nv_valid ? nv_rec : {FAC_MODBUS, FAC_FMT, BAUD_9600, FAC_TYPE, FAC_ADDR};
   wire [15:0] din_chg = s2_q ^ s3_q;
   wire [IRQ_W-1:0] irq_ev;
   assign irq_ev[IRQ_HTO]  = hto_ev;
   assign irq_ev[IRQ_MWDT] = mw_exp;
   assign irq_ev[IRQ_LOW]  = |(~din_q & ~latch_q & IN_MASK);
   assign irq_ev[IRQ_CMD]  = cmd_go;

   // AXI4-Lite slave
   always_ff @(posedge mclk) begin
      if (srst) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         rvalid_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0;
         wstrb_q   <= 4'h0;
         bresp_q   <= RESP_OK;
         rresp_q   <= RESP_OK;
         rdata_q   <= 32'h0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= w_map ? RESP_OK : RESP_ERR;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
         if (rd_go) begin
            rvalid_q <= 1'b1;
            rresp_q  <= RESP_OK;
            if (hit(ra, A_STAT)) begin
               rdata_q <= {21'h0, recov_q, rst_flag_q, tmo_q, tmo_q ? STS_TMO : STS_NORM};
            end else if (hit(ra, A_IO)) begin
               rdata_q <= {8'h00, dout_q, din_q};
            end else if (hit(ra, A_LATCH)) begin
               rdata_q <= {16'h0, latch_q};
            end else if (hit(ra, A_CFG)) begin
               rdata_q <= stage_q;
            end else if (hit(ra, A_VAL)) begin
               rdata_q <= {16'h0, safe_q, pon_q};
            end else if (hit(ra, A_HWDT)) begin
               rdata_q <= {16'h0, hwdt_int_q};
            end else if (hit(ra, A_IRQ)) begin
               rdata_q <= {28'h0, irq_stat_q};
            end else if (hit(ra, A_MASK)) begin
               rdata_q <= {28'h0, irq_mask_q};
            end else if (hit(ra, A_REPLY)) begin
               rdata_q <= {8'h00, rdat_q, reply_q};
            end else if (hit(ra, A_ACT)) begin
               rdata_q <= act_q[31:0];
            end else if (hit(ra, A_CMD) || hit(ra, A_KICK)) begin
               rdata_q <= 32'h0;
            end else begin
               rdata_q <= 32'h0;
               rresp_q <= RESP_ERR;
            end
         end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // pin stages keep sampling through srst, so a strap held across reset is seen by boot end
   always_ff @(posedge mclk) begin
      if (ce) begin
         s1_q <= din_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         r1_q <= recover_n_pin;
         r2_q <= r1_q;
         r3_q <= r2_q;
      end
   end

   // inputs: a bit moves once the second and third stages agree
   always_ff @(posedge mclk) begin
      if (srst) begin
         din_q   <= 16'hffff;
         strap_q <= 1'b1;
      end else if (ce) begin
         din_q   <= (s2_q & ~din_chg) | (din_q & din_chg);
         strap_q <= (r2_q == r3_q) ? r2_q : strap_q;
      end
   end

   // boot sequence; a module-watchdog expiry replays it without a bus reset
   always_ff @(posedge mclk) begin
      if (srst) begin
         st_q   <= ST_BOOT;
         boot_q <= 3'h0;
      end else if (ce) begin
         case (st_q)
            ST_BOOT: begin
               boot_q <= boot_q + 3'h1;
               if (boot_end) begin
                  st_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (mw_exp) begin
                  st_q   <= ST_BOOT;
                  boot_q <= 3'h0;
               end
            end
            default: st_q <= ST_BOOT;
         endcase
      end
   end

   // configuration is sampled only at boot end, so a saved record waits for the next boot
   always_ff @(posedge mclk) begin
      if (srst) begin
         act_q      <= '0;
         nvrec_q    <= '0;
         recov_q    <= 1'b0;
         dev_addr_q <= RECOV_ADDR;
         baud_div_q <= dow_baud_div(BAUD_9600);
         chk_q      <= 1'b0;
         proto_q    <= FAC_MODBUS;
         nvw_q      <= 1'b0;
      end else if (ce) begin
         nvw_q <= cmd_go && rec_go;
         if (boot_end) begin
            act_q   <= boot_rec;
            nvrec_q <= boot_rec;
            recov_q <= !strap_q;
            if (!strap_q) begin
               dev_addr_q <= RECOV_ADDR;
               baud_div_q <= dow_baud_div(BAUD_9600);
               chk_q      <= 1'b0;
            end else begin
               dev_addr_q <= boot_rec[7:0];
               baud_div_q <= dow_baud_div(boot_rec[23:16]);
               chk_q      <= boot_rec[24 + FMT_CHK];
            end
            proto_q <= boot_rec[NV_W-1];
         end else if (cmd_go && rec_go) begin
            nvrec_q <= rec_val;
         end
      end
   end

   // outputs, flags and replies
   always_ff @(posedge mclk) begin
      if (srst) begin
         dout_q     <= 8'h00;
         tmo_q      <= 1'b0;
         rst_flag_q <= 1'b0;
         nvt_q      <= 1'b0;
         reply_q    <= 8'h00;
         rdat_q     <= 16'h0;
         latch_q    <= 16'h0;
      end else if (ce) begin
         nvt_q <= hto_ev || (cmd_go && clr_tmo);
         if (boot_end) begin
            tmo_q      <= nv_tmo;
            dout_q     <= OUT_EN ? (nv_tmo ? safe_q : pon_q) : 8'h00;
            rst_flag_q <= 1'b1;
         end else begin
            tmo_q      <= hto_ev || (tmo_q && !(cmd_go && clr_tmo));
            rst_flag_q <= rst_flag_q && !(cmd_go && clr_rst);
            if (hto_ev && OUT_EN) begin
               dout_q <= safe_q;
            end else if (cmd_go && set_out) begin
               dout_q <= out_val;
            end
         end
         // a new low wins over the clearing read
         latch_q <= ((cmd_go && rd_latch) ? 16'h0 : latch_q) | (~din_q & IN_MASK);
         if (cmd_go) begin
            reply_q <= rep_ch;
            rdat_q  <= rep_dat;
         end
      end
   end

   // software registers and watchdog counters
   always_ff @(posedge mclk) begin
      if (srst) begin
         stage_q    <= {FAC_FMT, BAUD_9600, FAC_TYPE, FAC_ADDR};
         pon_q      <= PON_DEFAULT;
         safe_q     <= SAFE_DEFAULT;
         hwdt_int_q <= 16'h0;
         irq_mask_q <= '0;
         irq_stat_q <= '0;
         hw_tick_q  <= 32'h0;
         hw_units_q <= 16'h0;
         mw_cnt_q   <= 32'h0;
         mwdt_q     <= 1'b0;
      end else if (ce) begin
         if (w_cfg) stage_q <= merge(stage_q, wdata_q, wstrb_q);
         if (w_val) {safe_q, pon_q} <= 16'(merge({16'h0, safe_q, pon_q}, wdata_q, wstrb_q));
         if (w_hwdt) hwdt_int_q <= 16'(merge({16'h0, hwdt_int_q}, wdata_q, wstrb_q));
         if (w_mask) irq_mask_q <= IRQ_W'(merge(32'(irq_mask_q), wdata_q, wstrb_q));
         irq_stat_q <= irq_ev | (r_irq ? '0 : irq_stat_q);
         if (!hw_on || cmd_go || hto_ev) begin
            hw_tick_q  <= 32'h0;
            hw_units_q <= 16'h0;
         end else if (hw_tick) begin
            hw_tick_q  <= 32'h0;
            hw_units_q <= hw_units_q + 16'h1;
         end else begin
            hw_tick_q <= hw_tick_q + 32'h1;
         end
         mw_cnt_q <= (!running || w_kick || mw_exp) ? 32'h0 : mw_cnt_q + 32'h1;
         mwdt_q   <= mw_exp;
      end
   end

   assign s_axi_awready = !aw_hold_q && !bvalid_q;
   assign s_axi_wready  = !w_hold_q && !bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign dout          = dout_q;
   assign nv_rec_wr     = nvw_q;
   assign nv_rec_wdata  = nvrec_q;
   assign nv_tmo_wr     = nvt_q;
   assign nv_tmo_wdata  = tmo_q;
   assign dev_addr      = dev_addr_q;
   assign baud_div      = baud_div_q;
   assign chk_en        = chk_q;
   assign proto_modbus  = proto_q;
   assign recovery      = recov_q;
   assign mwdt_rst      = mwdt_q;
   assign irq           = |(irq_stat_q & irq_mask_q);

endmodule

// File: logic/dow_pkg.sv
package dow_pkg;

   // timing base
   localparam int unsigned CLK_HZ      = 20_000_000;
   localparam int unsigned CLK_NS      = 50;
   localparam int unsigned HWDT_UNIT_NS = 100_000_000;
   localparam int unsigned HWDT_UNIT_CYC = HWDT_UNIT_NS / CLK_NS;
   localparam int unsigned MWDT_NS     = 1_600_000_000;
   localparam int unsigned MWDT_CYC    = MWDT_NS / CLK_NS;
   localparam int unsigned BOOT_CYC    = 4;

   // register byte offsets
   localparam logic [7:0] A_CMD   = 8'h00;
   localparam logic [7:0] A_STAT  = 8'h04;
   localparam logic [7:0] A_IO    = 8'h08;
   localparam logic [7:0] A_LATCH = 8'h0c;
   localparam logic [7:0] A_CFG   = 8'h10;
   localparam logic [7:0] A_VAL   = 8'h14;
   localparam logic [7:0] A_HWDT  = 8'h18;
   localparam logic [7:0] A_IRQ   = 8'h1c;
   localparam logic [7:0] A_MASK  = 8'h20;
   localparam logic [7:0] A_KICK  = 8'h24;
   localparam logic [7:0] A_REPLY = 8'h28;
   localparam logic [7:0] A_ACT   = 8'h2c;

   localparam logic [1:0] RESP_OK  = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b10;

   // command word fields
   localparam int CMD_ARG = 8;
   localparam int CMD_SEL = 16;
   localparam int CMD_ADR = 24;

   // reply characters and status codes
   localparam logic [7:0] CH_DONE = 8'h3e;
   localparam logic [7:0] CH_ACK  = 8'h21;
   localparam logic [7:0] CH_IGN  = CH_ACK;
   localparam logic [7:0] CH_BAD  = 8'h3f;
   localparam logic [7:0] STS_TMO  = 8'h04;
   localparam logic [7:0] STS_NORM = 8'h00;

   // configuration record {proto, fmt, baud, type, addr}
   localparam int NV_W = 33;
   localparam logic [7:0] FAC_ADDR  = 8'h01;
   localparam logic [7:0] FAC_TYPE  = 8'h40;
   localparam logic [7:0] BAUD_9600 = 8'h06;
   localparam logic [7:0] FAC_FMT   = 8'h00;
   localparam logic       FAC_MODBUS = 1'b1;
   localparam logic [7:0] RECOV_ADDR = 8'h00;
   localparam int FMT_CHK = 6;

   // output group selectors
   localparam logic [7:0] GRP_A = 8'h00;
   localparam logic [7:0] GRP_B = 8'h0a;
   localparam logic [3:0] SGL_A = 4'h1;
   localparam logic [3:0] SGL_B = 4'ha;

   localparam int IRQ_HTO  = 0;
   localparam int IRQ_MWDT = 1;
   localparam int IRQ_LOW  = 2;
   localparam int IRQ_CMD  = 3;
   localparam int IRQ_W    = 4;

   typedef enum logic [3:0] {
      OP_STATUS  = 4'h0,
      OP_CLR_TMO = 4'h1,
      OP_RST_FLG = 4'h2,
      OP_IO      = 4'h3,
      OP_LATCH   = 4'h4,
      OP_OUT_ALL = 4'h5,
      OP_OUT_GRP = 4'h6,
      OP_SET_CFG = 4'h7,
      OP_PROTO   = 4'h8
   } dow_op_t;

   typedef enum logic [1:0] {
      ST_BOOT = 2'b01,
      ST_RUN  = 2'b10
   } dow_state_t;

   // bit-time in clock cycles for a baud code; unknown codes fall back to 9600
   function automatic logic [15:0] dow_baud_div(input logic [7:0] code);
      case (code)
         8'h03:   dow_baud_div = 16'(CLK_HZ / 1200);
         8'h04:   dow_baud_div = 16'(CLK_HZ / 2400);
         8'h05:   dow_baud_div = 16'(CLK_HZ / 4800);
         8'h07:   dow_baud_div = 16'(CLK_HZ / 19200);
         8'h08:   dow_baud_div = 16'(CLK_HZ / 38400);
         8'h09:   dow_baud_div = 16'(CLK_HZ / 57600);
         8'h0a:   dow_baud_div = 16'(CLK_HZ / 115200);
         default: dow_baud_div = 16'(CLK_HZ / 9600);
      endcase
   endfunction

endpackage

// File: test/dow_ctrl_assertions.sv
`timescale 1ns/1ps
module dow_ctrl_chk
   import dow_pkg::*;
(
   input wire logic        mclk,
   input wire logic        srst,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic [7:0]  dout,
   input wire logic        nv_rec_wr,
   input wire logic [7:0]  dev_addr,
   input wire logic [15:0] baud_div,
   input wire logic        chk_en,
   input wire logic        recovery,
   input wire logic        mwdt_rst,
   input wire logic        irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted during response");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted during response");
   a_recov_addr: assert property (recovery |-> dev_addr == RECOV_ADDR && !chk_en)
      else $error("recovery address or checksum wrong");
   a_recov_baud: assert property (recovery |-> baud_div == 16'd2083)
      else $error("recovery bit time wrong");
   a_nvwr_pulse: assert property (nv_rec_wr |=> !nv_rec_wr)
      else $error("record save not a pulse");
   a_mwdt_pulse: assert property (mwdt_rst |=> !mwdt_rst)
      else $error("module watchdog pulse too long");
   a_reset_quiet: assert property ($fell(srst) |-> dout == 8'h00 && !irq)
      else $error("outputs not idle after reset");
endmodule
bind dow_ctrl dow_ctrl_chk chk_i (.*);

// File: test/dow_nv_model.sv
`timescale 1ns/1ps
module dow_nv_model
   import dow_pkg::*;
(
   input  wire logic            mclk,
   input  wire logic            nv_rec_wr,
   input  wire logic [NV_W-1:0] nv_rec_wdata,
   input  wire logic            nv_tmo_wr,
   input  wire logic            nv_tmo_wdata,
   output logic                 nv_valid,
   output logic [NV_W-1:0]      nv_rec,
   output logic                 nv_tmo
);
   // ignores srst: contents must survive a reboot like a real store
   initial begin
      nv_valid = 1'b0;
      nv_rec   = '0;
      nv_tmo   = 1'b0;
   end
   always @(posedge mclk) begin
      if (nv_rec_wr) begin
         nv_valid <= 1'b1;
         nv_rec   <= nv_rec_wdata;
      end
      if (nv_tmo_wr)
         nv_tmo <= nv_tmo_wdata;
   end
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
   import dow_pkg::*;
   logic        mclk, srst, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, recover_n_pin;
   logic        nv_valid, nv_tmo, nv_rec_wr, nv_tmo_wr, nv_tmo_wdata, chk_en, proto_modbus, recovery;
   logic        mwdt_rst, irq;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [3:0]  s_axi_wstrb;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, dout, dev_addr, v;
   logic [15:0] din_pin, baud_div;
   logic [31:0] s_axi_wdata, s_axi_rdata, rep;
   logic [32:0] nv_rec, nv_rec_wdata;
   int          errors, tests_run, k;
   dow_ctrl #(.HWDT_UNIT(10), .MWDT_LEN(400), .PON_DEFAULT(8'h5a), .SAFE_DEFAULT(8'hc3)) dut (.*);
   dow_nv_model nv_i (.*);
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      @(posedge mclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(negedge mclk);
         ta = s_axi_awready & s_axi_awvalid;
         tw = s_axi_wready & s_axi_wvalid;
         tb = s_axi_bvalid;
         @(posedge mclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end while (!tb);
      s_axi_bready <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      logic ta, tv;
      @(posedge mclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(negedge mclk);
         ta  = s_axi_arready & s_axi_arvalid;
         tv  = s_axi_rvalid;
         rep = s_axi_rdata;
         rsp = s_axi_rresp;
         @(posedge mclk);
         if (ta) s_axi_arvalid <= 1'b0;
      end while (!tv);
      s_axi_rready <= 1'b0;
      #1;
   endtask
   // kick first so the module watchdog never fires in the middle of a command
   task automatic cmd(input logic [3:0] op, input logic [7:0] sel, input logic [7:0] arg);
      wr(A_KICK, 32'h0);
      wr(A_CMD, {dev_addr, sel, arg, 4'h0, op});
      rd(A_REPLY);
   endtask
   task automatic boot();
      @(posedge mclk);
      srst <= 1'b1;
      repeat (10) @(posedge mclk);
      srst <= 1'b0;
      cyc(8);
   endtask
   task automatic stop_test();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #2_000_000;
      errors++;
      stop_test();
   end
   initial begin
      {errors, tests_run} = '0;
      {srst, ce, recover_n_pin, s_axi_wstrb, din_pin} = {3'b111, 4'hf, 16'hffff};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      k = $urandom(90);
      boot();
      chk(32'(dev_addr), 32'(FAC_ADDR));
      chk(32'(dout), 32'h5a);
      wr(A_MASK, 32'h1);
      cmd(OP_RST_FLG, 8'h00, 8'h00);
      chk(rep, {16'h1, CH_ACK});
      cmd(OP_RST_FLG, 8'h00, 8'h00);
      chk(rep, {16'h0, CH_ACK});
      for (k = 0; k < 4; k++) begin
         v = 8'($urandom);
         cmd(OP_OUT_ALL, 8'h00, v);
         chk(32'(dout), 32'(v));
         chk(32'(rep[7:0]), 32'(CH_DONE));
      end
      cmd(OP_OUT_GRP, 8'h13, 8'h01);
      chk(32'(dout), 32'(v | 8'h08));
      rd(8'h30);
      chk(32'(rsp), 32'(RESP_ERR));
      k = $urandom_range(7, 0);
      @(posedge mclk);
      din_pin <= ~(16'h1 << k);
      cyc(6);
      @(posedge mclk);
      din_pin <= 16'hffff;
      cyc(6);
      rd(A_LATCH);
      chk(32'(rep[k]), 32'h1);
      wr(A_HWDT, 32'h1);
      @(posedge mclk);
      ce <= 1'b0;
      cyc(20);
      chk(32'(dout), 32'(v | 8'h08));
      @(posedge mclk);
      ce <= 1'b1;
      cyc(20);
      chk(32'(dout), 32'hc3);
      chk(32'(irq), 32'h1);
      cmd(OP_STATUS, 8'h00, 8'h00);
      chk(32'(rep[15:8]), 32'(STS_TMO));
      rd(A_IRQ);
      chk(32'(irq), 32'h0);
      cmd(OP_OUT_ALL, 8'h00, 8'h3c);
      chk({dout, rep[7:0]}, {8'hc3, CH_IGN});
      boot();
      chk(32'(dout), 32'hc3);
      cmd(OP_CLR_TMO, 8'h00, 8'h00);
      cmd(OP_OUT_ALL, 8'h00, 8'h3c);
      chk(32'(dout), 32'h3c);
      for (k = 0; k < 500 && !mwdt_rst; k++)
         cyc(1);
      chk(32'(mwdt_rst), 32'h1);
      cyc(6);
      chk(32'(dout), 32'h5a);
      cmd(OP_RST_FLG, 8'h00, 8'h00);
      chk(rep, {16'h1, CH_ACK});
      @(posedge mclk);
      recover_n_pin <= 1'b0;
      boot();
      chk({recovery, dev_addr, baud_div}, {1'b1, RECOV_ADDR, 16'd2083});
      rd(A_ACT);
      chk(rep, {FAC_FMT, BAUD_9600, FAC_TYPE, FAC_ADDR});
      cmd(OP_SET_CFG, 8'h00, 8'h00);
      chk({rep[7:0], dev_addr}, {CH_ACK, RECOV_ADDR});
      cmd(OP_PROTO, 8'h00, 8'h00);
      chk({rep[7:0], proto_modbus}, {CH_ACK, FAC_MODBUS});
      @(posedge mclk);
      recover_n_pin <= 1'b1;
      boot();
      chk(32'(proto_modbus), 32'h0);
      cmd(OP_PROTO, 8'h00, 8'h00);
      chk(32'(rep[7:0]), 32'(CH_BAD));
      wr(A_CFG, {FAC_FMT, 8'h07, FAC_TYPE, FAC_ADDR});
      cmd(OP_SET_CFG, 8'h00, 8'h00);
      chk(32'(rep[7:0]), 32'(CH_BAD));
      stop_test();
   end
endmodule
